// File: design/svw_supervisor_watchdog_reset.sv
// Purpose: Reset supervisor with manual reset input and watchdog timer.
// Assumes: Pins are asynchronous to clk_sys; rst is synchronous.
// Notes:   Both the active-low and active-high reset variants are driven.
//
// Overview of operation
// - Kick stuck past timeout expires watchdog, resets
// - Reset, manual reset, kick edges clear watchdog
// - Kick pulses of 150ns are recognised
// - Watchdog halts during reset, restarts on release
// - Manual reset low asserts, then holds period
// - Supply low asserts; hold period after recovery
// - Active-low and active-high outputs both driven
// - Watchdog expiry holds reset full hold period
// - Select low short hold, high long hold
// - Select change applies after running hold ends
// - Bouncing manual reset gives one clean reset
// - Watchdog timeout short or long version
// - Fixed hold option lasts 150 to 151ms
module svw_supervisor_watchdog_reset
   import svw_pkg::*;
#(
   parameter logic HAS_SELECT = 1'b1,
   parameter logic WDOG_LONG_VERSION = 1'b0,
   parameter logic [PRESCALE_W-1:0] TICK_COUNT = PRESCALE_W'(TICK_CYCLES),
   parameter logic [HOLD_W-1:0] HOLD_SHORT_TICKS = HOLD_W'(HOLD_SHORT_MS),
   parameter logic [HOLD_W-1:0] HOLD_LONG_TICKS = HOLD_W'(HOLD_LONG_MS),
   parameter logic [WDOG_W-1:0] WDOG_SHORT_TICKS = WDOG_W'(WDOG_SHORT_MS),
   parameter logic [WDOG_W-1:0] WDOG_LONG_TICKS = WDOG_W'(WDOG_LONG_MS)
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire svw_pkg::svw_pins_type pinsIn,
   output svw_pkg::svw_reset_type resetPins
);

   import svw_pkg::*;

   svw_regs_type r;
   svw_regs_type next_r;

   logic supplyLowS;
   logic manualLowS;
   logic kickEdge;
   logic selectS;
   logic cause;
   logic holdDone;
   logic wdogExpired;
   logic [HOLD_W-1:0] holdLimit;
   logic [WDOG_W-1:0] wdogLimit;

   // Hold length in ticks; one extra tick covers the partial first tick
   function automatic logic [HOLD_W-1:0] hold_ticks(input logic useLong);
      logic [HOLD_W-1:0] base;
      base = useLong ? HOLD_LONG_TICKS : HOLD_SHORT_TICKS;
      return base + HOLD_W'(1);
   endfunction : hold_ticks

   // Synchronised levels, read only from the second stage
   assign supplyLowS = r.supplySync[1];
   assign manualLowS = ~r.manualSync[1];
   assign selectS = r.selectSync[1];

   // Any held level longer than two clocks passes the synchroniser,
   // so a pulse of KICK_PULSE_MIN_CYCLES clocks is always seen
   assign kickEdge = r.kickSync[1] ^ r.kickSync[2];

   // Reset causes that hold the line asserted as a level
   assign cause = supplyLowS | manualLowS;

   assign holdLimit = hold_ticks(r.holdLong);
   assign holdDone = r.tick && (r.holdCnt + HOLD_W'(1) >= holdLimit);

   // Timeout version fixed by parameter
   assign wdogLimit = WDOG_LONG_VERSION ? WDOG_LONG_TICKS
                                        : WDOG_SHORT_TICKS;
   assign wdogExpired = r.tick && !kickEdge &&
                        (r.wdogCnt + WDOG_W'(1) >= wdogLimit);

   always_comb begin
      next_r = r;

      // Two-stage synchronisers on all pins
      next_r.supplySync = {r.supplySync[0], pinsIn.supplyLow};
      next_r.manualSync = {r.manualSync[0], pinsIn.manualResetN};
      next_r.kickSync = {r.kickSync[1:0], pinsIn.watchdogKickIn};
      next_r.selectSync = {r.selectSync[0], pinsIn.timeoutSelect};

      // Free-running millisecond time base
      if (r.prescale >= TICK_COUNT - PRESCALE_W'(1)) begin
         next_r.prescale = '0;
         next_r.tick = 1'b1;
      end else begin
         next_r.prescale = r.prescale + PRESCALE_W'(1);
         next_r.tick = 1'b0;
      end

      unique case (r.state)
         ST_ASSERT: begin
            // Watchdog held clear while reset is asserted
            next_r.wdogCnt = '0;
            next_r.holdCnt = '0;
            if (!cause) begin
               next_r.state = ST_HOLD;
               // Select sampled once, at the start of the hold
               next_r.holdLong = HAS_SELECT ? selectS : 1'b1;
            end
         end
         ST_HOLD: begin
            next_r.wdogCnt = '0;
            if (cause) begin
               // A bounce low restarts the whole sequence
               next_r.state = ST_ASSERT;
               next_r.holdCnt = '0;
            end else if (holdDone) begin
               next_r.state = ST_RUN;
               next_r.holdCnt = '0;
            end else if (r.tick) begin
               // holdLong kept steady until the hold ends
               next_r.holdCnt = r.holdCnt + HOLD_W'(1);
            end
         end
         ST_RUN: begin
            next_r.holdCnt = '0;
            if (cause) begin
               next_r.state = ST_ASSERT;
               next_r.wdogCnt = '0;
            end else if (wdogExpired) begin
               next_r.state = ST_HOLD;
               next_r.wdogCnt = '0;
               next_r.holdLong = HAS_SELECT ? selectS : 1'b1;
            end else if (kickEdge) begin
               next_r.wdogCnt = '0;
            end else if (r.tick) begin
               // Counting resumes as soon as the line releases
               next_r.wdogCnt = r.wdogCnt + WDOG_W'(1);
            end
         end
         default: begin
            // Unused state code falls back to asserting reset
            next_r.state = ST_ASSERT;
            next_r.holdCnt = '0;
            next_r.wdogCnt = '0;
         end
      endcase

      // Output pins follow the next state so they stay in step with it
      next_r.resetPins.resetOutN = (next_r.state == ST_RUN);
      next_r.resetPins.resetOut = (next_r.state != ST_RUN);
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         r.supplySync <= SUPPLY_SYNC_RST;
         r.manualSync <= MANUAL_SYNC_RST;
         r.kickSync <= KICK_SYNC_RST;
         r.selectSync <= SELECT_SYNC_RST;
         // Power-up behaves like supply recovery: assert, then hold
         r.state <= ST_ASSERT;
         r.holdLong <= 1'b1;
         r.prescale <= '0;
         r.tick <= 1'b0;
         r.holdCnt <= '0;
         r.wdogCnt <= '0;
         r.resetPins.resetOutN <= 1'b0;
         r.resetPins.resetOut <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign resetPins = r.resetPins;

endmodule : svw_supervisor_watchdog_reset

// File: design/svw_pkg.sv
// Purpose: Shared constants and types for the reset supervisor.
// Assumes: clk_sys at 50 MHz; time base tick of one millisecond.
// Notes:   Timing figures are kept in their own units; cycle counts derive.
package svw_pkg;

   // Clock and time base
   localparam int CLK_PERIOD_NS = 20;
   localparam int TICK_PERIOD_NS = 1000000;
   localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int PRESCALE_W = 16;

   // Shortest kick pulse that must be seen, and its least cycle count
   localparam int KICK_PULSE_MIN_NS = 150;
   localparam int KICK_PULSE_MIN_CYCLES =
      (KICK_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Reset hold period, milliseconds (least values)
   localparam int HOLD_SHORT_MS = 10;
   localparam int HOLD_LONG_MS = 150;
   localparam int HOLD_W = 9;

   // Watchdog timeout period, milliseconds (typical values)
   localparam int WDOG_SHORT_MS = 3300;
   localparam int WDOG_LONG_MS = 209000;
   localparam int WDOG_W = 18;

   // Synchroniser reset levels: supply good, manual reset released
   localparam logic [1:0] SUPPLY_SYNC_RST = 2'h0;
   localparam logic [1:0] MANUAL_SYNC_RST = 2'h3;
   localparam logic [2:0] KICK_SYNC_RST = 3'h0;
   localparam logic [1:0] SELECT_SYNC_RST = 2'h0;

   typedef enum logic [1:0] {
      ST_ASSERT,
      ST_HOLD,
      ST_RUN
   } svw_state_type;

   // Pins as they arrive, before synchronisation
   typedef struct packed {
      logic supplyLow;
      logic manualResetN;
      logic watchdogKickIn;
      logic timeoutSelect;
   } svw_pins_type;

   // Both output variants of the reset line
   typedef struct packed {
      logic resetOutN;
      logic resetOut;
   } svw_reset_type;

   typedef struct packed {
      logic [1:0] supplySync;
      logic [1:0] manualSync;
      logic [2:0] kickSync;
      logic [1:0] selectSync;
      svw_state_type state;
      logic holdLong;
      logic [PRESCALE_W-1:0] prescale;
      logic tick;
      logic [HOLD_W-1:0] holdCnt;
      logic [WDOG_W-1:0] wdogCnt;
      svw_reset_type resetPins;
   } svw_regs_type;

endpackage : svw_pkg

// File: dv/svw_checker.sv
// Purpose: Port assertions for the reset supervisor.
// Assumes: Short watchdog version.
// Notes:   Bound into every supervisor instance.
module svw_checker
   import svw_pkg::*;
#(
   parameter logic [PRESCALE_W-1:0] TICK_COUNT = 16'h0004,
   parameter logic [HOLD_W-1:0] HOLD_LONG_TICKS = 9'h006,
   parameter logic [WDOG_W-1:0] WDOG_SHORT_TICKS = 18'h00014
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire svw_pkg::svw_pins_type pinsIn,
   input wire svw_pkg::svw_reset_type resetPins
);
   localparam int HOLD_MAX = (HOLD_LONG_TICKS + 1) * TICK_COUNT + 6;
   localparam int WD_MAX = WDOG_SHORT_TICKS * TICK_COUNT + 6;
   int held;
   int quiet;
   logic kickQ;
   logic cause;
   logic rOut;
   assign cause = pinsIn.supplyLow | ~pinsIn.manualResetN;
   assign rOut = resetPins.resetOut;
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   // Cycles in a hold with no cause, and cycles without a kick edge
   always_ff @(posedge clk_sys) begin
      kickQ <= pinsIn.watchdogKickIn;
      held <= (rOut && !cause && !rst) ? held + 1 : 0;
      quiet <= (rOut || kickQ != pinsIn.watchdogKickIn) ? 0 : quiet + 1;
   end
   pol_match_a: assert property (rOut != resetPins.resetOutN)
      else $error("outputs not inverse");
   rst_assert_a: assert property (disable iff (1'b0) rst |=> rOut)
      else $error("rst not asserted");
   mr_assert_a: assert property (!pinsIn.manualResetN [*2] |-> ##3 rOut)
      else $error("manual reset missed");
   sup_assert_a: assert property (pinsIn.supplyLow [*2] |-> ##3 rOut)
      else $error("supply low missed");
   hold_min_a: assert property ($fell(cause) |-> ##3 rOut [*8])
      else $error("hold too short");
   hold_max_a: assert property (held <= HOLD_MAX)
      else $error("hold too long");
   expiry_hold_a: assert property ($rose(rOut) |-> rOut [*8])
      else $error("reset pulse short");
   wd_max_a: assert property (quiet <= WD_MAX)
      else $error("watchdog late");
endmodule : svw_checker

bind svw_supervisor_watchdog_reset svw_checker #(.TICK_COUNT(TICK_COUNT),
   .HOLD_LONG_TICKS(HOLD_LONG_TICKS), .WDOG_SHORT_TICKS(WDOG_SHORT_TICKS))
   i_chk (.clk_sys(clk_sys), .rst(rst), .pinsIn(pinsIn), .resetPins(resetPins));

// File: dv/svw_host_model.sv
// Purpose: Host that kicks the watchdog input.
// Assumes: mode 0 idle, 1 level toggles, 3 pulses of 8 cycles.
// Notes:   No kicks while the host is held in reset.
module svw_host_model #(
   parameter int GAP = 40
) (
   input wire logic clk_sys,
   input wire logic resetOut,
   input wire logic [1:0] mode,
   output logic kickOut
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0;
   logic kickLvl = 1'b0;
   assign kickOut = kickLvl;
   always @(posedge clk_sys) begin
      cnt <= (resetOut || !mode[0] || cnt == GAP + 8) ? 0 : cnt + 1;
      if (!resetOut && mode[0] && (cnt == GAP || (mode[1] && cnt == GAP + 8)))
         kickLvl <= !kickLvl;
   end
endmodule : svw_host_model

// File: dv/test_supervisor_watchdog_reset.sv
// Purpose: Self-checking bench for the reset supervisor.
// Assumes: Tick of 4 cycles; holds of 3 and 6 ticks; watchdog 20.
// Notes:   Hold windows allow for tick phase and sync delay.
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
   bad_count++; $display("wrong value %s %0h %0h", nm, e, g); end end
module test_supervisor_watchdog_reset;
   import svw_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TK = 4, HS = 3, HL = 6, WD = 20;
   logic clk_sys = 0, rst = 1, sup = 0, mrN = 1, sel = 0, kick;
   logic [1:0] mode = 2'h0;
   svw_reset_type resetPins;
   int bad_count = 0, n_compared = 0, n;
   svw_supervisor_watchdog_reset #(.TICK_COUNT(PRESCALE_W'(TK)),
      .HOLD_SHORT_TICKS(HOLD_W'(HS)), .HOLD_LONG_TICKS(HOLD_W'(HL)),
      .WDOG_SHORT_TICKS(WDOG_W'(WD))) i_dut (.clk_sys(clk_sys), .rst(rst),
      .pinsIn({sup, mrN, kick, sel}), .resetPins(resetPins));
   svw_host_model i_host (.clk_sys(clk_sys), .resetOut(resetPins.resetOut),
      .mode(mode), .kickOut(kick));
   initial forever #10 clk_sys = ~clk_sys;
   task automatic complete_run();
      $display("compared %0d wrong %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : complete_run
   // Cycles the reset output stays at lvl; the 300 bound means a hang
   task automatic span(input logic lvl, input int lim);
      n = 0;
      @(negedge clk_sys);
      while (resetPins.resetOut === lvl && n < lim) begin
         @(negedge clk_sys);
         n++;
      end
      if (n == 300) begin
         bad_count++;
         complete_run();
      end
   endtask : span
   task automatic hold_is(input string nm, input int t, input int pre);
      span(1'b1, 300);
      `CHK(nm, 1'b1, n + pre >= t * TK && n + pre <= (t + 1) * TK + 6)
   endtask : hold_is
   task automatic t_manual(input logic s, input logic flip);
      @(posedge clk_sys);
      sel <= s;
      mrN <= 1'b0;
      repeat (6) @(posedge clk_sys);
      mrN <= 1'b1;
      `CHK("manual", 1'b1, resetPins.resetOut)
      repeat (6) @(posedge clk_sys);
      sel <= s ^ flip;
      hold_is("hold", s ? HL : HS, 6);
   endtask : t_manual
   task automatic t_bounce_supply();
      // Earlier scenarios leave the select high; the short hold is wanted
      @(posedge clk_sys);
      sel <= 1'b0;
      repeat (4) begin
         @(posedge clk_sys);
         mrN <= 1'b0;
         repeat (3) @(posedge clk_sys);
         mrN <= 1'b1;
         repeat (2) @(posedge clk_sys);
      end
      hold_is("bounce", HS, 3);
      @(posedge clk_sys);
      sup <= 1'b1;
      repeat (6) @(posedge clk_sys);
      `CHK("low out", 1'b0, resetPins.resetOutN)
      sup <= 1'b0;
      hold_is("supply", HS, 0);
   endtask : t_bounce_supply
   task automatic t_watchdog();
      @(posedge clk_sys);
      mode <= 2'h1;
      span(1'b0, 250);
      `CHK("kicked", 250, n)
      @(posedge clk_sys);
      mode <= 2'h3;
      span(1'b0, 250);
      `CHK("pulsed", 250, n)
      @(posedge clk_sys);
      mode <= 2'h0;
      span(1'b0, 300);
      hold_is("expiry", HS, 0);
      span(1'b0, 300);
      `CHK("restart", 1'b1, n >= (WD - 1) * TK && n <= WD * TK + 3)
   endtask : t_watchdog
   initial begin
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      hold_is("power-up", HS, 0);
      t_manual(1'b0, 1'b0);
      t_manual(1'b1, 1'b0);
      t_manual(1'b1, 1'b1);
      t_manual(1'b0, 1'b1);
      t_bounce_supply();
      t_watchdog();
      complete_run();
   end
endmodule : test_supervisor_watchdog_reset
